// [src/lapb_regs.svh]
// constants for the link frame procedure engine and its peer end
// assumes: included by bare name; one 200 MHz clock, sync reset
//
// Summary of operation
// - classify frames; wrong role is undefined
// - no I-frame before set-up completes
// - I-frames only on host transmit request
// - establish command sends SABM/SABME, awaits UA
// - received SABM/SABME answered by UA
// - release sends DISC; UA or DM completes
// - DISC sent or received blocks I-frames
// - received DISC answered by UA
// - N(R) acknowledges all earlier N(S)
// - busy-clear command sends RR, ends busy
// - out-of-sequence I-frame triggers REJ; code sends FRMR instead if N(S) is half the modulus or more past V(R)
// - busy-set sends RNR; RNR while busy
// - RNR stops I-frames until RR
// - resend SABM/SABME on each T1 expiry
// - resend DISC; N2 failures mean disconnected
// - DM refuses set-up; unsolicited F=0 invites
// - FRMR for unrecoverable frame errors
// - N(R) valid only from V(A) to V(S)
// - after FRMR, error recovery until set-up
// - X.75 mode reports other errors, W=1
// - FRMR field: control, V(S), C/R, V(R), WXYZ
// - UI/TEST/XID need option bit, else undefined
`ifndef LAPB_REGS_SVH
`define LAPB_REGS_SVH

`define ADR_CMD 4'h0
`define ADR_CFG 4'h4
`define ADR_STAT 4'h8
`define ADR_T1 4'hc

`define CMD_W 6
`define CMD_TX1 0
`define CMD_TX2 1
`define CMD_EST 2
`define CMD_REL 3
`define CMD_BSET 4
`define CMD_BCLR 5

`define CFG_MOD128 0
`define CFG_X75 1
`define CFG_OPT 2
`define CFG_N2 15:8
`define N2_RST 8'h03
`define T1_RST 16'h0400

`define U_PF_MASK 8'hef
`define U_SABM 8'h2f
`define U_SABME 8'h6f
`define U_DM 8'h0f
`define U_FRMR 8'h87
`define U_DISC 8'h43
`define U_UA 8'h63
`define U_UI 8'h03
`define U_XID 8'haf
`define U_TEST 8'he3
`define S_RR 8'h01
`define S_RNR 8'h05
`define S_REJ 8'h09

`define MASK8 7'h07
`define MASK128 7'h7f
`define BUF_ONE 8'h01
`define BUF_TWO 8'h02

`endif

// [src/lapb_pkg.sv]
// types shared by both link ends and the frame classifier
// assumes: nothing beyond the constants header
package lapb_pkg;

  typedef enum logic [3:0] {
    fk_i, fk_rr, fk_rnr, fk_rej, fk_sabm, fk_disc, fk_ua, fk_dm,
    fk_frmr, fk_ui, fk_xid, fk_test, fk_undef
  } frame_kind_t;

  // one frame as seen above the bit framing layer
  typedef struct packed {
    logic [15:0] ctrl;
    logic resp;
    logic has_info;
    logic oversize;
    logic [39:0] info;
  } frame_t;

  typedef enum logic [2:0] {
    st_disc, st_setup, st_info, st_release, st_err
  } link_state_t;

  typedef struct packed {
    link_state_t state;
    logic [6:0] vs;
    logic [6:0] va;
    logic [6:0] vr;
    logic local_busy;
    logic remote_busy;
    logic refused;
    logic [7:0] retry;
    logic [15:0] t1_cnt;
    logic [5:0] pend;
    logic mod128;
    logic x75;
    logic opt_en;
    logic [7:0] n2;
    logic [15:0] t1_load;
    logic tx_valid;
    frame_t tx_frame;
    logic wb_ack;
    logic [31:0] wb_dat;
  } station_state_t;

  typedef struct packed {
    logic remote_busy;
    logic rcv_valid;
    frame_t rcv_frame;
  } peer_state_t;

endpackage

// [src/lapb_link_if.sv]
// frame-level link joining the station and the remote peer
// assumes: both ends on the same clock; valid/ready per direction
`timescale 1ns/1ps
interface lapb_link_if;
  import lapb_pkg::*;
  logic s2p_valid;
  logic s2p_ready;
  frame_t s2p_frame;
  logic p2s_valid;
  logic p2s_ready;
  frame_t p2s_frame;

  modport station (
    output s2p_valid, s2p_frame, p2s_ready,
    input s2p_ready, p2s_valid, p2s_frame
  );
  modport peer (
    input s2p_valid, s2p_frame, p2s_ready,
    output s2p_ready, p2s_valid, p2s_frame
  );
endinterface

// [src/lapb_classify.sv]
// combinational control field decoder
// assumes: first control octet in ctrl[7:0], second in ctrl[15:8]
`timescale 1ns/1ps
`include "lapb_regs.svh"
module lapb_classify import lapb_pkg::*; (
  input wire logic [15:0] i_ctrl,
  input wire logic i_resp,
  input wire logic i_has_info,
  input wire logic i_mod128,
  input wire logic i_opt_en,
  output frame_kind_t o_kind,
  output logic o_undef,
  output logic o_info_bad
);
  frame_kind_t kind;
  logic cmd_ok;
  logic rsp_ok;
  logic info_ok;

  always_comb begin
    kind = fk_undef;
    cmd_ok = 1'b1;
    rsp_ok = 1'b1;
    info_ok = 1'b0;
    if (!i_ctrl[0]) begin
      kind = fk_i;
      rsp_ok = 1'b0;
      info_ok = 1'b1;
    end else if (!i_ctrl[1]) begin
      if (!i_mod128 || i_ctrl[7:4] == 4'h0) begin
        case ({4'h0, i_ctrl[3:0]})
          `S_RR: kind = fk_rr;
          `S_RNR: kind = fk_rnr;
          `S_REJ: kind = fk_rej;
          default: kind = fk_undef;
        endcase
      end
    end else begin
      case (i_ctrl[7:0] & `U_PF_MASK)
        `U_SABM: if (!i_mod128) kind = fk_sabm;
        `U_SABME: if (i_mod128) kind = fk_sabm;
        `U_DISC: kind = fk_disc;
        `U_UA: kind = fk_ua;
        `U_DM: kind = fk_dm;
        `U_FRMR: kind = fk_frmr;
        // optional frames gated by option bit
        `U_UI: if (i_opt_en) kind = fk_ui;
        `U_XID: if (i_opt_en) kind = fk_xid;
        `U_TEST: if (i_opt_en) kind = fk_test;
        default: kind = fk_undef;
      endcase
      rsp_ok = kind inside {fk_ua, fk_dm, fk_frmr, fk_ui, fk_xid,
                            fk_test};
      cmd_ok = kind inside {fk_sabm, fk_disc, fk_ui, fk_xid, fk_test};
      info_ok = kind inside {fk_frmr, fk_ui, fk_xid, fk_test};
    end
    o_info_bad = i_has_info && !info_ok && kind != fk_undef;
    o_undef = kind == fk_undef || (i_resp ? !rsp_ok : !cmd_ok) ||
              o_info_bad;
    o_kind = o_undef ? fk_undef : kind;
  end
endmodule

// [src/lapb_station.sv]
// station end: frame procedure engine with a Wishbone register port
// assumes: classic Wishbone master; peer end on the link interface
`timescale 1ns/1ps
`include "lapb_regs.svh"
module lapb_station import lapb_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  lapb_link_if.station link,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  station_state_t s;
  station_state_t next_s;
  frame_t rf;
  frame_kind_t kind;
  logic undef;
  logic info_bad;
  logic [`CMD_W-1:0] wr;
  logic [`CMD_W-1:0] served;
  logic [31:0] rdat;
  logic [6:0] mask;
  logic [6:0] nr;
  logic [6:0] ns;
  logic [6:0] nsd;
  logic pf;
  logic nr_ok;
  logic rx;
  logic t1_exp;
  logic go;
  logic frmr;
  logic [3:0] cause;
  frame_t snd;

  assign rf = link.p2s_frame;
  assign link.p2s_ready = !s.tx_valid;
  assign link.s2p_valid = s.tx_valid;
  assign link.s2p_frame = s.tx_frame;
  assign o_wb_ack = s.wb_ack;
  assign o_wb_dat = s.wb_dat;

  lapb_classify u_classify (
    .i_ctrl(rf.ctrl),
    .i_resp(rf.resp),
    .i_has_info(rf.has_info),
    .i_mod128(s.mod128),
    .i_opt_en(s.opt_en),
    .o_kind(kind),
    .o_undef(undef),
    .o_info_bad(info_bad)
  );

  function automatic frame_t mk_u(logic [7:0] code, logic p, logic r);
    mk_u = '0;
    mk_u.ctrl = {8'h00, code | {3'h0, p, 4'h0}};
    mk_u.resp = r;
  endfunction

  function automatic frame_t mk_s(logic [7:0] code, logic [6:0] n,
                                  logic m128);
    mk_s = '0;
    mk_s.ctrl = m128 ? {n, 1'b0, code} : {8'h00, n[2:0], 1'b0, code[3:0]};
    mk_s.resp = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    wr = '0;
    served = '0;
    rdat = 32'h0000_0000;
    go = 1'b0;
    frmr = 1'b0;
    cause = 4'h0;
    snd = '0;
    mask = s.mod128 ? `MASK128 : `MASK8;
    nr = s.mod128 ? rf.ctrl[15:9] : {4'h0, rf.ctrl[7:5]};
    ns = s.mod128 ? rf.ctrl[7:1] : {4'h0, rf.ctrl[3:1]};
    pf = (s.mod128 && kind inside {fk_i, fk_rr, fk_rnr, fk_rej}) ?
         rf.ctrl[8] : rf.ctrl[4];
    nr_ok = ((nr - s.va) & mask) <= ((s.vs - s.va) & mask);
    nsd = (ns - s.vr) & mask;
    rx = link.p2s_valid && !s.tx_valid;
    t1_exp = s.t1_cnt == 16'h0001 && !s.tx_valid && !rx;

    // register port: ack one cycle after request, then drop
    next_s.wb_ack = i_wb_cyc && i_wb_stb && !s.wb_ack;
    if (s.wb_ack && i_wb_cyc && i_wb_stb && i_wb_we) begin
      case (i_wb_adr)
        `ADR_CMD: if (i_wb_sel[0]) wr = i_wb_dat[`CMD_W-1:0];
        `ADR_CFG: begin
          if (i_wb_sel[0]) begin
            next_s.mod128 = i_wb_dat[`CFG_MOD128];
            next_s.x75 = i_wb_dat[`CFG_X75];
            next_s.opt_en = i_wb_dat[`CFG_OPT];
          end
          if (i_wb_sel[1]) next_s.n2 = i_wb_dat[`CFG_N2];
        end
        `ADR_T1: begin
          if (i_wb_sel[0]) next_s.t1_load[7:0] = i_wb_dat[7:0];
          if (i_wb_sel[1]) next_s.t1_load[15:8] = i_wb_dat[15:8];
        end
        default: ;
      endcase
    end else if (next_s.wb_ack && !i_wb_we) begin
      case (i_wb_adr)
        `ADR_CMD: rdat = {26'h000_0000, s.pend};
        `ADR_CFG: rdat = {16'h0000, s.n2, 5'h00, s.opt_en, s.x75,
                          s.mod128};
        `ADR_STAT: rdat = {1'b0, s.va, 1'b0, s.vr, 1'b0, s.vs, 2'h0,
                           s.refused, s.remote_busy, s.local_busy,
                           s.state};
        `ADR_T1: rdat = {16'h0000, s.t1_load};
        default: rdat = 32'h0000_0000;
      endcase
    end
    next_s.wb_dat = rdat;

    if (s.tx_valid && link.s2p_ready) next_s.tx_valid = 1'b0;
    // timer holds at a count of 1 while the link slot is busy
    if (s.t1_cnt != 16'h0000 && !(s.t1_cnt == 16'h0001 &&
        (s.tx_valid || rx))) next_s.t1_cnt = s.t1_cnt - 16'h0001;

    ////////////////////////////////////////////////////////////////////
    if (rx) begin
      if (undef) begin
        frmr = 1'b1;
        cause = {2'b00, info_bad, 1'b1};
      end else begin
        case (kind)
          fk_sabm: begin
            // answer set-up with UA, leaves recovery
            go = 1'b1;
            snd = mk_u(`U_UA, pf, 1'b1);
            next_s.state = st_info;
            next_s.vs = '0;
            next_s.va = '0;
            next_s.vr = '0;
            next_s.remote_busy = 1'b0;
            next_s.t1_cnt = '0;
          end
          fk_disc: begin
            // answer DISC with UA, link down
            go = 1'b1;
            snd = mk_u(`U_UA, pf, 1'b1);
            next_s.state = st_disc;
            next_s.t1_cnt = '0;
          end
          fk_ua: begin
            if (s.state == st_setup) begin
              next_s.state = st_info;
              next_s.vs = '0;
              next_s.va = '0;
              next_s.vr = '0;
              next_s.remote_busy = 1'b0;
              next_s.t1_cnt = '0;
            end else if (s.state == st_release) begin
              next_s.state = st_disc;
              next_s.t1_cnt = '0;
            end else if (s.state == st_info) begin
              frmr = 1'b1;
              cause = {3'b000, s.x75};
            end
          end
          fk_dm: begin
            if (s.state == st_setup || s.state == st_release) begin
              next_s.refused = s.state == st_setup;
              next_s.state = st_disc;
              next_s.t1_cnt = '0;
            end else if (s.state == st_disc && !pf) begin
              go = 1'b1;
              snd = mk_u(s.mod128 ? `U_SABME : `U_SABM, 1'b0, 1'b0);
              next_s.state = st_setup;
              next_s.retry = '0;
              next_s.t1_cnt = s.t1_load;
            end else if (s.state == st_info) begin
              frmr = 1'b1;
              cause = {3'b000, s.x75};
            end
          end
          fk_frmr: if (s.state == st_info) begin
            go = 1'b1;
            snd = mk_u(s.mod128 ? `U_SABME : `U_SABM, 1'b0, 1'b0);
            next_s.state = st_setup;
            next_s.retry = '0;
            next_s.t1_cnt = s.t1_load;
          end
          fk_i, fk_rr, fk_rnr, fk_rej: if (s.state == st_info) begin
            if (rf.oversize) begin
              frmr = 1'b1;
              cause = 4'b0100;
            end else if (!nr_ok) begin
              frmr = 1'b1;
              cause = 4'b1000;
            end else if (kind != fk_i && rf.resp && pf) begin
              frmr = 1'b1;
              cause = {3'b000, s.x75};
            end else if (kind == fk_i && nsd != 7'h00 &&
                         (s.mod128 ? nsd[6] : nsd[2])) begin
              frmr = 1'b1;
              cause = {3'b000, s.x75};
            end else begin
              next_s.va = nr;
              if (kind == fk_rnr) next_s.remote_busy = 1'b1;
              if (kind == fk_rr) next_s.remote_busy = 1'b0;
              // resend is left to the host, which watches V(S)
              if (kind == fk_rej) next_s.vs = nr;
              if (kind == fk_i) begin
                go = 1'b1;
                if (nsd != 7'h00) begin
                  snd = mk_s(`S_REJ, s.vr, s.mod128);
                end else if (s.local_busy) begin
                  snd = mk_s(`S_RNR, s.vr, s.mod128);
                end else begin
                  next_s.vr = (s.vr + 7'h01) & mask;
                  snd = mk_s(`S_RR, next_s.vr, s.mod128);
                end
              end
            end
          end
          default: ;
        endcase
      end
    end else if (!s.tx_valid) begin
      if (t1_exp) begin
        if (s.state == st_setup) begin
          go = 1'b1;
          snd = mk_u(s.mod128 ? `U_SABME : `U_SABM, 1'b0, 1'b0);
          next_s.t1_cnt = s.t1_load;
        end else if (s.retry + 8'h01 >= s.n2) begin
          // give up release, recovery by set-up
          if (s.state == st_err) begin
            go = 1'b1;
            snd = mk_u(s.mod128 ? `U_SABME : `U_SABM, 1'b0, 1'b0);
            next_s.state = st_setup;
            next_s.t1_cnt = s.t1_load;
          end else begin
            next_s.state = st_disc;
          end
          next_s.retry = '0;
        end else begin
          next_s.retry = s.retry + 8'h01;
          next_s.t1_cnt = s.t1_load;
          if (s.state == st_release) begin
            go = 1'b1;
            snd = mk_u(`U_DISC, 1'b0, 1'b0);
          end
        end
      end else if (s.pend[`CMD_EST]) begin
        served[`CMD_EST] = 1'b1;
        go = 1'b1;
        snd = mk_u(s.mod128 ? `U_SABME : `U_SABM, 1'b0, 1'b0);
        next_s.state = st_setup;
        next_s.refused = 1'b0;
        next_s.retry = '0;
        next_s.t1_cnt = s.t1_load;
      end else if (s.pend[`CMD_REL]) begin
        served[`CMD_REL] = 1'b1;
        go = 1'b1;
        snd = mk_u(`U_DISC, 1'b0, 1'b0);
        next_s.state = st_release;
        next_s.retry = '0;
        next_s.t1_cnt = s.t1_load;
      end else if (s.pend[`CMD_BSET]) begin
        served[`CMD_BSET] = 1'b1;
        go = 1'b1;
        snd = mk_s(`S_RNR, s.vr, s.mod128);
        next_s.local_busy = 1'b1;
      end else if (s.pend[`CMD_BCLR]) begin
        served[`CMD_BCLR] = 1'b1;
        go = 1'b1;
        snd = mk_s(`S_RR, s.vr, s.mod128);
        next_s.local_busy = 1'b0;
      end else if ((s.pend[`CMD_TX1] || s.pend[`CMD_TX2]) &&
                   s.state == st_info && !s.remote_busy &&
                   ((s.vs - s.va) & mask) != mask) begin
        // I-frame only when linked, asked, peer ready
        served[`CMD_TX1] = s.pend[`CMD_TX1];
        served[`CMD_TX2] = !s.pend[`CMD_TX1];
        go = 1'b1;
        snd.ctrl = s.mod128 ? {s.vr, 1'b0, s.vs, 1'b0} :
                   {8'h00, s.vr[2:0], 1'b0, s.vs[2:0], 1'b0};
        snd.has_info = 1'b1;
        snd.info[7:0] = s.pend[`CMD_TX1] ? `BUF_ONE : `BUF_TWO;
        next_s.vs = (s.vs + 7'h01) & mask;
      end
    end

    if (frmr) begin
      go = 1'b1;
      snd = mk_u(`U_FRMR, 1'b0, 1'b1);
      snd.has_info = 1'b1;
      snd.info = s.mod128 ?
        {4'h0, cause, s.vr, rf.resp, s.vs, 1'b0, rf.ctrl} :
        {16'h0000, 4'h0, cause, s.vr[2:0], rf.resp, s.vs[2:0], 1'b0,
         rf.ctrl[7:0]};
      next_s.state = st_err;
      next_s.retry = '0;
      next_s.t1_cnt = s.t1_load;
    end
    if (go) begin
      next_s.tx_valid = 1'b1;
      next_s.tx_frame = snd;
    end
    // a command written while served stays pending
    next_s.pend = (s.pend & ~served) | wr;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= '0;
      s.n2 <= `N2_RST;
      s.t1_load <= `T1_RST;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [src/lapb_peer.sv]
// remote peer end: passes user frames onto the link, reports arrivals
// assumes: user holds send valid and frame until send ready
`timescale 1ns/1ps
`include "lapb_regs.svh"
module lapb_peer import lapb_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  lapb_link_if.peer link,
  input wire logic i_mod128,
  input wire logic i_send_valid,
  input wire frame_t i_send_frame,
  output logic o_send_ready,
  output logic o_rcv_valid,
  output frame_t o_rcv_frame,
  output logic o_remote_busy
);
  peer_state_t p;
  peer_state_t next_p;
  frame_kind_t kind;
  logic block;

  lapb_classify u_classify (
    .i_ctrl(link.s2p_frame.ctrl),
    .i_resp(link.s2p_frame.resp),
    .i_has_info(link.s2p_frame.has_info),
    .i_mod128(i_mod128),
    .i_opt_en(1'b1),
    .o_kind(kind),
    .o_undef(),
    .o_info_bad()
  );

  // no new I-frame toward a busy station
  assign block = p.remote_busy && !i_send_frame.ctrl[0];
  assign link.p2s_valid = i_send_valid && !block;
  assign link.p2s_frame = i_send_frame;
  assign o_send_ready = link.p2s_ready && !block;
  assign link.s2p_ready = 1'b1;
  assign o_rcv_valid = p.rcv_valid;
  assign o_rcv_frame = p.rcv_frame;
  assign o_remote_busy = p.remote_busy;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_p = p;
    next_p.rcv_valid = link.s2p_valid;
    if (link.s2p_valid) begin
      next_p.rcv_frame = link.s2p_frame;
      // busy from RNR until RR; set-up clears it
      if (kind == fk_rnr) next_p.remote_busy = 1'b1;
      if (kind == fk_rr || kind == fk_sabm || kind == fk_ua)
        next_p.remote_busy = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end
endmodule

// [tb/lapb_link_props.sv]
// assertions on the frame link between station and peer ends
// assumes: modulo 8 operation; placed beside the link by the bench
`timescale 1ns/1ps
`include "lapb_regs.svh"
module lapb_link_props import lapb_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic s2p_valid,
  input wire logic s2p_ready,
  input wire frame_t s2p_frame,
  input wire logic p2s_valid,
  input wire logic p2s_ready,
  input wire frame_t p2s_frame
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] sc;
  logic [7:0] pc;
  logic take;
  logic busy;
  assign sc = s2p_frame.ctrl[7:0] & `U_PF_MASK;
  assign pc = p2s_frame.ctrl[7:0] & `U_PF_MASK;
  assign take = p2s_valid && p2s_ready && !p2s_frame.resp
    && !p2s_frame.has_info;
  ////////////////////////////////////////////////////////////////////
  // peer's view of station busy, same timing as its own flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
    end else if (s2p_valid && s2p_ready) begin
      if (s2p_frame.ctrl[3:0] == 4'h5) begin
        busy <= 1'b1;
      end else if (s2p_frame.ctrl[3:0] == 4'h1 || sc == `U_UA ||
                   sc == `U_SABM) begin
        busy <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  resp_role_a: assert property (
    s2p_valid && (sc == `U_UA || sc == `U_DM || sc == `U_FRMR)
    |-> s2p_frame.resp) else $error("response sent as command");
  cmd_role_a: assert property (
    s2p_valid && (sc == `U_SABM || sc == `U_DISC || !s2p_frame.ctrl[0])
    |-> !s2p_frame.resp) else $error("command sent as response");
  no_info_a: assert property (
    s2p_valid && (sc == `U_SABM || sc == `U_DISC)
    |-> !s2p_frame.has_info) else $error("set-up frame with info");
  sabm_ua_a: assert property (
    take && pc == `U_SABM |=> s2p_valid && sc == `U_UA && s2p_frame.resp
    && s2p_frame.ctrl[4] == $past(p2s_frame.ctrl[4]))
    else $error("no UA after SABM");
  disc_ua_a: assert property (
    take && pc == `U_DISC |=> s2p_valid && sc == `U_UA && s2p_frame.resp)
    else $error("no UA after DISC");
  frmr_cause_a: assert property (
    s2p_valid && sc == `U_FRMR |-> s2p_frame.info[23:20] == 4'h0
    && !s2p_frame.info[8] && (s2p_frame.info[16] || !s2p_frame.info[17]))
    else $error("bad reject field");
  ifr_req_a: assert property (
    s2p_valid && !s2p_frame.ctrl[0] |-> s2p_frame.info[7:0] == 8'h01
    || s2p_frame.info[7:0] == 8'h02) else $error("data frame unrequested");
  rnr_stop_a: assert property (
    busy |-> !(p2s_valid && !p2s_frame.ctrl[0]))
    else $error("data frame sent to busy station");
  slot_busy_a: assert property (
    s2p_valid |-> !p2s_ready) else $error("frame taken while slot full");
endmodule

// [tb/tb_top.sv]
// bench joining station and peer ends over the frame link
// assumes: modulo 8 only; drives Wishbone and the peer user side
`timescale 1ns/1ps
`include "lapb_regs.svh"
module tb_top import lapb_pkg::*;;
  logic clk, rst_n, cyc, stb, we, ack, sv, sr, rv, rb;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, seed, d;
  logic [2:0] vr;
  frame_t sf, rf;
  int miscompares, total_checks;
  lapb_link_if lapb_link_if_i ();
  lapb_station lapb_station_i (.i_clk(clk), .i_rst_n(rst_n),
    .link(lapb_link_if_i), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
    .o_wb_ack(ack));
  lapb_peer lapb_peer_i (.i_clk(clk), .i_rst_n(rst_n),
    .link(lapb_link_if_i), .i_mod128(1'b0), .i_send_valid(sv),
    .i_send_frame(sf), .o_send_ready(sr), .o_rcv_valid(rv),
    .o_rcv_frame(rf), .o_remote_busy(rb));
  lapb_link_props lapb_link_props_i (.i_clk(clk), .i_rst_n(rst_n),
    .s2p_valid(lapb_link_if_i.s2p_valid),
    .s2p_ready(lapb_link_if_i.s2p_ready),
    .s2p_frame(lapb_link_if_i.s2p_frame),
    .p2s_valid(lapb_link_if_i.p2s_valid),
    .p2s_ready(lapb_link_if_i.p2s_ready),
    .p2s_frame(lapb_link_if_i.p2s_frame));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang();
    chk("wait", 1, 0);
    summarize();
  endtask
  // every wait is bounded; a hang ends the run
  task automatic wb(logic w, logic [3:0] a, logic [31:0] v);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) hang();
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rx(logic [7:0] m, logic [7:0] e, logic r);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rv !== 1'b1 && n < 400);
    if (rv !== 1'b1) hang();
    chk("ctrl", {24'h0, e}, {24'h0, rf.ctrl[7:0] & m});
    chk("resp", {31'h0, r}, {31'h0, rf.resp});
  endtask
  task automatic tx(logic [7:0] c, logic r);
    int n = 0;
    sv <= 1'b1;
    sf <= '{ctrl: {8'h00, c}, resp: r, info: {8'h00, rnd()},
      default: '0};
    do begin
      @(posedge clk);
      n++;
    end while (sr !== 1'b1 && n < 50);
    if (sr !== 1'b1) hang();
    sv <= 1'b0;
  endtask
  task automatic quiet();
    logic s = 1'b0;
    repeat (60) begin
      @(posedge clk);
      if (rv === 1'b1 && rf.ctrl[0] === 1'b0) s = 1'b1;
    end
    chk("no data frame", 0, {31'h0, s});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_n, cyc, stb, we, sv, adr, wdat, vr} = '0;
    sf = '0;
    seed = 32'd74521;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1, `ADR_T1, 32'h0000_0028);
    wb(0, `ADR_T1, 0);
    chk("t1", 32'h0000_0028, d);
    wb(0, 4'h2, 0);
    chk("unmapped", 0, d);
    wb(0, `ADR_CFG, 0);
    chk("cfg", 32'h0000_0300, d);
    wb(0, `ADR_STAT, 0);
    chk("stat", 0, d);
    $display("test registers done");
    wb(1, `ADR_CMD, 32'h0000_0001);
    quiet();
    wb(1, `ADR_CMD, 32'h0000_0004);
    rx(8'hef, `U_SABM, 0);
    tx(`U_DM | (rf.ctrl[7:0] & 8'h10), 1);
    wb(0, `ADR_STAT, 0);
    chk("refused", 32'h0000_0020, d & 32'h0000_0027);
    tx(`U_DM, 1);
    rx(8'hef, `U_SABM, 0);
    rx(8'hef, `U_SABM, 0);
    wb(1, `ADR_CMD, 32'h0000_0001);
    tx(`U_UA | (rf.ctrl[7:0] & 8'h10), 1);
    rx(8'h0f, 8'h00, 0);
    chk("info", 1, {24'h0, rf.info[7:0]});
    wb(0, `ADR_STAT, 0);
    chk("stat", 32'h0000_0102, d & 32'h7f7f_7f07);
    tx(8'h21, 1);
    wb(0, `ADR_STAT, 0);
    chk("ack", 32'h0100_0102, d & 32'h7f7f_7f07);
    $display("test set-up done");
    repeat (16) begin
      d = rnd();
      if (d[0]) begin
        tx({3'd1, d[1], vr + 3'd1 + {2'd0, d[3]}, 1'b0}, 0);
        rx(8'hef, {vr, 5'h09}, 1);
      end else begin
        tx({3'd1, d[1], vr, 1'b0}, 0);
        vr = vr + 3'd1;
        rx(8'hef, {vr, 5'h01}, 1);
      end
    end
    wb(0, `ADR_STAT, 0);
    chk("vr", {29'h0, vr}, {29'h0, d[18:16]});
    $display("test traffic done");
    wb(1, `ADR_CMD, 32'h0000_0010);
    rx(8'hef, {vr, 5'h05}, 1);
    chk("busy", 1, {31'h0, rb});
    sv <= 1'b1;
    sf.ctrl <= {8'h00, 3'd1, 1'b0, vr, 1'b0};
    repeat (10) begin
      @(posedge clk);
      chk("held", 0, {31'h0, sr});
    end
    sv <= 1'b0;
    wb(1, `ADR_CMD, 32'h0000_0020);
    rx(8'hef, {vr, 5'h01}, 1);
    chk("busy", 0, {31'h0, rb});
    // station side: peer RNR holds back requested data frames
    tx(8'h25, 1);
    wb(1, `ADR_CMD, 32'h0000_0001);
    quiet();
    tx(8'h21, 1);
    rx(8'h0f, 8'h02, 0);
    $display("test busy done");
    tx(8'h0d, 0);
    rx(8'hef, `U_FRMR, 1);
    chk("frmr", {16'h0001, vr, 5'h04, 8'h0d}, rf.info[31:0]);
    wb(0, `ADR_STAT, 0);
    chk("error", 4, {29'h0, d[2:0]});
    tx(8'h3f, 0);
    rx(8'hff, 8'h73, 1);
    wb(0, `ADR_STAT, 0);
    chk("restart", 2, d & 32'h7f7f_7f07);
    wb(1, `ADR_CFG, 32'h0000_0302);
    tx(`U_UA, 1);
    rx(8'hef, `U_FRMR, 1);
    chk("x75 cause", 32'h0001_1063, rf.info[31:0]);
    tx(`U_UI, 0);
    rx(8'hef, `U_FRMR, 1);
    chk("ui undefined", 32'h0001_0003, rf.info[31:0]);
    $display("test reject done");
    wb(1, `ADR_CMD, 32'h0000_0008);
    rx(8'hef, `U_DISC, 0);
    tx(`U_DM | (rf.ctrl[7:0] & 8'h10), 1);
    wb(0, `ADR_STAT, 0);
    chk("released", 0, {29'h0, d[2:0]});
    wb(1, `ADR_CMD, 32'h0000_0002);
    quiet();
    tx(8'h53, 0);
    rx(8'hff, 8'h73, 1);
    wb(1, `ADR_CMD, 32'h0000_0008);
    repeat (3) rx(8'hef, `U_DISC, 0);
    quiet();
    wb(0, `ADR_STAT, 0);
    chk("gave up", 0, {29'h0, d[2:0]});
    $display("test release done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(0, `ADR_CFG, 0);
    chk("cfg reset", {16'h0000, `N2_RST, 8'h00}, d);
    wb(0, `ADR_CMD, 0);
    chk("pend reset", 0, d);
    $display("test reset done");
    summarize();
  end
endmodule
